// file: src/sxs_alu.sv
/*
 * Execution datapath for subtract-accumulator-from-register, XOR with a
 * literal, XOR with a register and nibble exchange, with the accumulator,
 * the status flags and the write-back port to the register file.
 * Assumes the decoder presents one operation per cycle with the register
 * operand already read from the register file, all on sys_clk.
 */
// Overview of operation
// RULE1 - Subtract acc from register, set carry, nibble, zero
// RULE2 - Target bit picks accumulator or register write-back
// RULE3 - XOR literal into accumulator, only zero flag
// RULE4 - XOR acc with register, only zero flag
// RULE5 - Swap register nibbles, no flags touched
// RULE6 - Accept 7-bit register address and target bit
`include "sxs_consts.svh"
`default_nettype none

module sxs_alu
    import sxs_pkg::*;
#(
    parameter int DW = `SXS_DATA_W,
    parameter int AW = `SXS_ADDR_W
) (
    // Clock and reset
    input  wire logic           sys_clk,
    input  wire logic           rstn,
    // Operation from the decoder
    input  wire logic           op_valid,
    input  wire sxs_op_t        op_code,
    input  wire logic [AW-1:0]  reg_addr,
    input  wire logic           target_sel,
    input  wire logic [DW-1:0]  literal,
    input  wire logic [DW-1:0]  reg_operand,
    // Accumulator load by other instructions
    input  wire logic           acc_load,
    input  wire logic [DW-1:0]  acc_load_data,
    // Register file write-back
    output logic                reg_wr_en,
    output logic [AW-1:0]       reg_wr_addr,
    output logic [DW-1:0]       reg_wr_data,
    // Architectural state
    output logic [DW-1:0]       acc_value,
    output logic                carry_flag,
    output logic                nibble_borrow_flag,
    output logic                zero_flag,
    output logic                op_done
);

    sxs_alu_if #(.DW(DW)) alu_bus ();

    logic [DW-1:0] acc_r;
    logic          carry_r;
    logic          nib_r;
    logic          zero_r;
    logic          wr_en_r;
    logic [AW-1:0] wr_addr_r;
    logic [DW-1:0] wr_data_r;
    logic          done_r;
    logic          take;
    logic          to_reg;

    sxs_alu_core #(.DW(DW)) sxs_alu_core_inst (
        .bus (alu_bus)
    );

    // Present the operands to the core
    assign alu_bus.op      = op_code;
    assign alu_bus.acc     = acc_r;
    assign alu_bus.operand = reg_operand;
    assign alu_bus.literal = literal;

    // An illegal code is dropped whole: only a pending load changes state, no done pulse
    assign take   = op_valid && alu_bus.legal;
    // The literal form always lands in the accumulator
    assign to_reg = (target_sel == `SXS_TGT_REG) && (op_code != SXS_OP_XOR_LITERAL); // [RULE2]

    // Accumulator: operation result has priority over a plain load
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            acc_r <= `SXS_ACC_RST;
        end else if (take && !to_reg) begin
            acc_r <= alu_bus.result;                        // [RULE2] [RULE3]
        end else if (acc_load && !take) begin
            acc_r <= acc_load_data;
        end
    end

    // Carry and nibble borrow change only on the subtraction
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            carry_r <= `SXS_FLAG_RST;
            nib_r   <= `SXS_FLAG_RST;
        end else if (take && alu_bus.upd_carry) begin
            carry_r <= alu_bus.c_flag;                      // [RULE1]
            nib_r   <= alu_bus.nb_flag;                     // [RULE1]
        end
    end

    // Null-result flag; the nibble exchange leaves it alone
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            zero_r <= `SXS_FLAG_RST;
        end else if (take && alu_bus.upd_zero) begin
            zero_r <= alu_bus.z_flag;                       // [RULE1] [RULE3] [RULE4]
        end
    end

    // Write-back strobe, one cycle after the operation is taken
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_en_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            wr_en_r <= take && to_reg;                      // [RULE2] [RULE5]
            done_r  <= take;
        end
    end

    // Address and data held until the next write, so they never glitch
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else if (take && to_reg) begin
            wr_addr_r <= reg_addr;                          // [RULE6]
            wr_data_r <= alu_bus.result;                    // [RULE2] [RULE4]
        end
    end

    assign reg_wr_en          = wr_en_r;
    assign reg_wr_addr        = wr_addr_r;
    assign reg_wr_data        = wr_data_r;
    assign acc_value          = acc_r;
    assign carry_flag         = carry_r;
    assign nibble_borrow_flag = nib_r;
    assign zero_flag          = zero_r;
    assign op_done            = done_r;

    // Helper reference values, computed apart from the core
    logic [DW-1:0] ref_sub;
    logic [DW-1:0] ref_xl;
    logic [DW-1:0] ref_xr;
    logic [DW-1:0] ref_swp;
    logic          ref_c;
    logic          ref_nb;
    logic          ref_legal;
    logic          is_sub;
    logic          is_xl;
    logic          is_xr;
    logic          is_swp;

    assign ref_sub = reg_operand + (~acc_r) + {{(DW-1){1'b0}}, 1'b1};
    assign ref_xl  = literal ^ acc_r;
    assign ref_xr  = reg_operand ^ acc_r;
    assign ref_swp = {reg_operand[`SXS_NIB_W-1:0], reg_operand[DW-1:DW-`SXS_NIB_W]};
    assign ref_c   = !(acc_r > reg_operand);
    assign ref_nb  = !(acc_r[`SXS_NIB_W-1:0] > reg_operand[`SXS_NIB_W-1:0]);
    // Legal codes are exactly one bit set, judged apart from the core decode
    assign ref_legal = $onehot(op_code);
    assign is_sub  = op_valid && op_code == SXS_OP_SUB_ACC_FROM_REG;
    assign is_xl   = op_valid && op_code == SXS_OP_XOR_LITERAL;
    assign is_xr   = op_valid && op_code == SXS_OP_XOR_ACC_REG;
    assign is_swp  = op_valid && op_code == SXS_OP_NIBBLE_EXCHANGE;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Subtraction result and flags land together in the accumulator
    a_sub_to_acc: assert property (is_sub && !target_sel |=> // [RULE1]
        acc_value == $past(ref_sub) && carry_flag == $past(ref_c)
        && nibble_borrow_flag == $past(ref_nb) && zero_flag == ($past(ref_sub) == '0))
        else $error("subtract to accumulator wrong");

    a_sub_to_reg: assert property (is_sub && target_sel |=> // [RULE2]
        reg_wr_en && reg_wr_data == $past(ref_sub) && $stable(acc_value)
        ##1 !reg_wr_en || $past(op_valid))
        else $error("subtract write-back wrong");

    a_xorl_acc: assert property (is_xl |=> // [RULE3]
        acc_value == $past(ref_xl) && !reg_wr_en && $stable(carry_flag)
        && $stable(nibble_borrow_flag) && zero_flag == ($past(ref_xl) == '0))
        else $error("literal xor wrong");

    a_xorr_route: assert property (is_xr |=> // [RULE4]
        (($past(target_sel) && reg_wr_data == $past(ref_xr) && reg_wr_en)
        || (!$past(target_sel) && acc_value == $past(ref_xr)))
        && $stable(carry_flag) && zero_flag == ($past(ref_xr) == '0))
        else $error("register xor wrong");

    a_swap_flags: assert property (is_swp |=> // [RULE5]
        $stable(carry_flag) && $stable(nibble_borrow_flag) && $stable(zero_flag))
        else $error("nibble exchange touched a flag");

    a_swap_data: assert property (is_swp |=> // [RULE5]
        $past(target_sel) ? reg_wr_data == $past(ref_swp) : acc_value == $past(ref_swp))
        else $error("nibble exchange data wrong");

    // Only legal register-target codes write back; refused codes are checked below
    a_wb_addr: assert property ((is_sub || is_xr || is_swp) && target_sel |=> // [RULE6]
        reg_wr_addr == $past(reg_addr) && op_done)
        else $error("write-back address wrong");

    a_no_wb_acc: assert property (op_valid && !target_sel |=> // [RULE2]
        !reg_wr_en)
        else $error("write-back without register target");

    // A code that is not one-hot changes nothing but a pending load
    a_illegal_drop: assert property (op_valid && !ref_legal |=> // [RULE6]
        !op_done && !reg_wr_en && $stable(carry_flag) && $stable(nibble_borrow_flag)
        && $stable(zero_flag))
        else $error("refused code changed state");

    // A load lands unless a legal operation is taken, whatever its target
    a_load_acc: assert property (acc_load && !(op_valid && ref_legal) |=> // [RULE2]
        acc_value == $past(acc_load_data))
        else $error("accumulator load lost");

    // Reset clears the visible state by the next edge, at power-up and mid-run
    a_reset_clear: assert property (disable iff (1'b0) !rstn |=> // [RULE2]
        acc_value == `SXS_ACC_RST && carry_flag == `SXS_FLAG_RST
        && nibble_borrow_flag == `SXS_FLAG_RST && zero_flag == `SXS_FLAG_RST
        && !reg_wr_en && !op_done)
        else $error("reset left state behind");

    c_sub_borrow: cover property (is_sub && acc_r > reg_operand);
    c_sub_to_reg: cover property (is_sub && target_sel);
    c_xorl_zero:  cover property (is_xl && literal == acc_r);
    c_swap_back:  cover property (is_swp ##1 is_swp);
    c_illegal_load: cover property (op_valid && !ref_legal && acc_load);

endmodule : sxs_alu

`default_nettype wire

// file: src/sxs_alu_core.sv
/*
 * Combinational result and flag logic for the four operations.
 * Assumes the controller registers everything it produces.
 */
`include "sxs_consts.svh"
`default_nettype none

module sxs_alu_core
    import sxs_pkg::*;
#(
    parameter int DW = `SXS_DATA_W
) (
    // Operands in, result and flags out
    sxs_alu_if.core bus
);

    logic [DW:0] diff;

    // Borrow-inverse comes from the extra bit of a widened subtraction
    always_comb begin
        diff          = {1'b0, bus.operand} - {1'b0, bus.acc};      // [RULE1]
        bus.result    = '0;
        bus.upd_carry = 1'b0;
        bus.upd_zero  = 1'b0;
        bus.legal     = 1'b1;
        unique case (bus.op)
            SXS_OP_SUB_ACC_FROM_REG: begin
                bus.result    = diff[DW-1:0];                       // [RULE1]
                bus.upd_carry = 1'b1;
                bus.upd_zero  = 1'b1;
            end
            SXS_OP_XOR_LITERAL: begin
                bus.result    = bus.acc ^ bus.literal;              // [RULE3]
                bus.upd_zero  = 1'b1;
            end
            SXS_OP_XOR_ACC_REG: begin
                bus.result    = bus.acc ^ bus.operand;              // [RULE4]
                bus.upd_zero  = 1'b1;
            end
            SXS_OP_NIBBLE_EXCHANGE: begin
                bus.result    = {bus.operand[`SXS_LO_NIB_MSB:0],
                                 bus.operand[DW-1:`SXS_HI_NIB_LSB]}; // [RULE5]
            end
            default: begin
                bus.legal     = 1'b0;   // Non one-hot code from a faulty decoder
            end
        endcase
    end

    // Flags: no borrow when acc <= operand, same on the low nibble
    assign bus.c_flag  = ~diff[DW];                                              // [RULE1]
    assign bus.nb_flag = (bus.acc[`SXS_LO_NIB_MSB:0] <= bus.operand[`SXS_LO_NIB_MSB:0]); // [RULE1]
    assign bus.z_flag  = (bus.result == '0);

endmodule : sxs_alu_core

`default_nettype wire

// file: src/sxs_alu_if.sv
/*
 * Carrier between the datapath control and its combinational core.
 * Assumes both ends run inside one clock domain.
 */
`default_nettype none

interface sxs_alu_if #(
    parameter int DW = 8
);
    import sxs_pkg::*;

    sxs_op_t          op;
    logic [DW-1:0]    acc;
    logic [DW-1:0]    operand;
    logic [DW-1:0]    literal;
    logic [DW-1:0]    result;
    logic             c_flag;
    logic             nb_flag;
    logic             z_flag;
    logic             upd_carry;    // Op writes carry and nibble borrow
    logic             upd_zero;     // Op writes the null-result flag
    logic             legal;

    modport core (input op, acc, operand, literal,
                  output result, c_flag, nb_flag, z_flag, upd_carry, upd_zero, legal);
    modport ctrl (output op, acc, operand, literal,
                  input result, c_flag, nb_flag, z_flag, upd_carry, upd_zero, legal);
endinterface : sxs_alu_if

`default_nettype wire

// file: src/sxs_consts.svh
/*
 * Constants for the subtract / XOR / nibble-exchange datapath: widths,
 * field positions and reset values.
 * Assumes it is included by bare name from files under src/.
 */
`ifndef SXS_CONSTS_SVH
`define SXS_CONSTS_SVH

`define SXS_DATA_W      8           // Operand and result width
`define SXS_ADDR_W      7           // Register address width, 0 to 127
`define SXS_NIB_W       4           // Nibble width
`define SXS_LO_NIB_MSB  3           // Low nibble is bits 3:0
`define SXS_HI_NIB_LSB  4           // High nibble is bits 7:4
`define SXS_ACC_RST     8'h00       // Accumulator after reset
`define SXS_FLAG_RST    1'h0        // Status flags after reset
`define SXS_TGT_ACC     1'h0        // Target select: accumulator
`define SXS_TGT_REG     1'h1        // Target select: memory register

`endif

// file: src/sxs_pkg.sv
/*
 * Types shared by the datapath modules.
 * Assumes sxs_consts.svh is reachable on the include path.
 */
`default_nettype none

package sxs_pkg;

    // One-hot operation codes presented by the instruction decoder
    typedef enum logic [3:0] {
        SXS_OP_SUB_ACC_FROM_REG = 4'h1,     // sub_acc_from_reg_op
        SXS_OP_XOR_LITERAL      = 4'h2,     // xor_literal_into_acc_op
        SXS_OP_XOR_ACC_REG      = 4'h4,     // xor_acc_with_reg_op
        SXS_OP_NIBBLE_EXCHANGE  = 4'h8      // nibble_exchange_op
    } sxs_op_t;

endpackage : sxs_pkg

`default_nettype wire

// file: tb/sxs_alu_tb_top.sv
/*
 * Self-checking bench: each operation with boundary operands,
 * judging accumulator, flags and write-back.
 * Assumes sxs_rf_model stands in for the register file.
 */
`default_nettype none

module sxs_alu_tb_top
    import sxs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, target_sel = 1'b0, acc_load = 1'b0;
    sxs_op_t op_code = SXS_OP_XOR_LITERAL;
    logic [6:0] reg_addr = 7'h00, reg_wr_addr;
    logic [7:0] literal = 8'h00, acc_load_data = 8'h00, reg_operand, reg_wr_data, acc_value;
    logic reg_wr_en, carry_flag, nibble_borrow_flag, zero_flag, op_done;
    logic [7:0] e_acc = 8'h00;
    logic e_c = 1'b0, e_nb = 1'b0, e_z = 1'b0;
    int failures = 0, checks = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    sxs_alu #(.DW(8), .AW(7)) sxs_alu_inst (
        .sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
        .reg_addr(reg_addr), .target_sel(target_sel), .literal(literal),
        .reg_operand(reg_operand), .acc_load(acc_load), .acc_load_data(acc_load_data),
        .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .acc_value(acc_value), .carry_flag(carry_flag),
        .nibble_borrow_flag(nibble_borrow_flag), .zero_flag(zero_flag), .op_done(op_done));

    sxs_rf_model sxs_rf_model_inst (
        .sys_clk(sys_clk), .rd_addr(reg_addr), .rd_data(reg_operand),
        .wr_en(reg_wr_en), .wr_addr(reg_wr_addr), .wr_data(reg_wr_data));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Accumulator set through the load port used by other instructions
    task automatic load(input logic [7:0] v);
        @(posedge sys_clk);
        acc_load <= 1'b1;
        acc_load_data <= v;
        @(posedge sys_clk);
        acc_load <= 1'b0;
        e_acc = v;
    endtask : load

    // One op: expectation first, then drive, then judge the next cycle
    task automatic run_op(input sxs_op_t code, input logic [6:0] addr, input logic tgt,
                          input logic [7:0] lit, input logic [7:0] opnd);
        logic [7:0] res;
        logic       to_reg;
        to_reg = tgt && (code != SXS_OP_XOR_LITERAL);
        case (code)
            SXS_OP_SUB_ACC_FROM_REG: begin
                res = opnd - e_acc;
                e_c = (e_acc <= opnd);
                e_nb = (e_acc[3:0] <= opnd[3:0]);
            end
            SXS_OP_XOR_LITERAL: res = e_acc ^ lit;
            SXS_OP_XOR_ACC_REG: res = e_acc ^ opnd;
            default: res = {opnd[3:0], opnd[7:4]};
        endcase
        if (code != SXS_OP_NIBBLE_EXCHANGE) e_z = (res == 8'h00);
        if (!to_reg) e_acc = res;
        sxs_rf_model_inst.preset(addr, opnd);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code <= code;
        reg_addr <= addr;
        target_sel <= tgt;
        literal <= lit;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        chk(acc_value, e_acc);
        chk({carry_flag, nibble_borrow_flag, zero_flag}, {e_c, e_nb, e_z});
        chk({reg_wr_en, op_done}, {to_reg, 1'b1});
        if (to_reg) chk(reg_wr_data, res);
        if (to_reg) chk({1'b0, reg_wr_addr}, {1'b0, addr});
        @(posedge sys_clk);
        #1;
        chk({reg_wr_en, op_done}, 8'h00);
    endtask : run_op

    // Subtract at borrow and nibble boundaries, both targets, edge addresses
    task automatic t_sub;
        logic [7:0] av [4] = '{8'h01, 8'h10, 8'h11, 8'h0f};
        logic [7:0] ov [4] = '{8'h10, 8'h10, 8'h10, 8'h20};
        logic [6:0] a;
        for (int i = 0; i < 4; i++) begin
            a = (i == 1) ? 7'h7f : 7'(i * 5);
            load(av[i]);
            run_op(SXS_OP_SUB_ACC_FROM_REG, a, ~i[0], 8'h00, ov[i]);
        end
        $display("Test sub done");
    endtask : t_sub

    // Literal XOR ignores the target bit; then two ops on consecutive edges
    task automatic t_xorl;
        load(8'h5a);
        run_op(SXS_OP_XOR_LITERAL, 7'h03, 1'b1, 8'hff, 8'h00);
        run_op(SXS_OP_XOR_LITERAL, 7'h03, 1'b0, 8'ha5, 8'h00);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        literal <= 8'h0f;
        @(posedge sys_clk);
        literal <= 8'hf0;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        chk(acc_value, 8'hff);
        chk({zero_flag, carry_flag}, {1'b0, e_c});
        e_acc = 8'hff;
        e_z = 1'b0;
        $display("Test xor literal done");
    endtask : t_xorl

    // Register XOR with zero result to the register, then exchange
    task automatic t_xorr_swap;
        load(8'h3c);
        run_op(SXS_OP_XOR_ACC_REG, 7'h7f, 1'b1, 8'h00, 8'h3c);
        run_op(SXS_OP_XOR_ACC_REG, 7'h00, 1'b0, 8'h00, 8'hc3);
        run_op(SXS_OP_NIBBLE_EXCHANGE, 7'h11, 1'b1, 8'h00, 8'h12);
        // Zero result must leave the null flag alone
        run_op(SXS_OP_NIBBLE_EXCHANGE, 7'h22, 1'b0, 8'h00, 8'h00);
        $display("Test xor register and exchange done");
    endtask : t_xorr_swap

    // Refused code beside a load, a load beside a legal op, then a reset mid-run
    task automatic t_refuse;
        load(8'h96);
        sxs_rf_model_inst.preset(7'h05, 8'h33);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code <= sxs_op_t'(4'h3);
        reg_addr <= 7'h05;
        target_sel <= 1'b1;
        acc_load <= 1'b1;
        acc_load_data <= 8'h44;
        @(posedge sys_clk);
        op_code <= SXS_OP_XOR_ACC_REG;
        target_sel <= 1'b0;
        acc_load_data <= 8'h55;
        #1;
        chk(acc_value, 8'h44);
        chk({reg_wr_en, op_done}, 8'h00);
        chk({carry_flag, nibble_borrow_flag, zero_flag}, {e_c, e_nb, e_z});
        @(posedge sys_clk);
        op_valid <= 1'b0;
        acc_load <= 1'b0;
        #1;
        chk(acc_value, 8'h77);
        chk({reg_wr_en, op_done, zero_flag}, 8'h02);
        // Second reset: outputs clear during it and at the first edge after
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        chk(acc_value, 8'h00);
        chk({carry_flag, nibble_borrow_flag, zero_flag, reg_wr_en, op_done}, 8'h00);
        @(posedge sys_clk);
        #1;
        chk(acc_value, 8'h00);
        chk({carry_flag, nibble_borrow_flag, zero_flag, reg_wr_en, op_done}, 8'h00);
        e_acc = 8'h00;
        e_c = 1'b0;
        e_nb = 1'b0;
        e_z = 1'b0;
        $display("Test refuse and reset done");
    endtask : t_refuse

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(acc_value, 8'h00);
        t_sub();
        t_xorl();
        t_xorr_swap();
        t_refuse();
        conclude();
    end

    // Watchdog, far beyond the sixty or so cycles the tests need
    initial begin
        repeat (2000) @(posedge sys_clk);
        failures++;
        conclude();
    end
endmodule : sxs_alu_tb_top

`default_nettype wire

// file: tb/sxs_rf_model.sv
/*
 * Register file model: 128 bytes, read at the addressed location.
 * Assumes the bench presets locations between clock edges.
 */
`default_nettype none

module sxs_rf_model (
    // Clock
    input  wire logic       sys_clk,
    // Read and write-back sides
    input  wire logic [6:0] rd_addr,
    output logic      [7:0] rd_data,
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_r [128];

    // Read is combinational, so the operand rides with the op
    assign rd_data = mem_r[rd_addr];

    // Write-back lands at the edge that sees the strobe
    always @(posedge sys_clk) begin
        if (wr_en === 1'b1) mem_r[wr_addr] <= wr_data;
    end

    // Bench preset; kept off clock edges to avoid racing a write-back
    task automatic preset(input logic [6:0] a, input logic [7:0] v);
        mem_r[a] = v;
    endtask : preset
endmodule : sxs_rf_model

`default_nettype wire
